/* File: hw/quadrature_pulse_counter.sv */
// quadrature / pulse counter channel with classic wishbone registers
//
// Chosen here: the register offsets and the Wishbone slave port.
module quadrature_pulse_counter #(
  parameter int TICK_DIV = qpc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  // register bus
  input  wire qpc_pkg::wb_req_t wbReq,
  output qpc_pkg::wb_rsp_t     wbRsp,
  // sensor pins
  input  wire qpc_pkg::pins_t  pins,
  // count reached request
  output logic                 irqReq
);
  import qpc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0]       sync1;
    logic [3:0]       sync2;
    logic [1:0]       prevCnt;
    mode_t            mode;
    logic             wide;
    logic             timerMode;
    logic [3:0]       invert;
    logic [2:0]       swShadow;
    logic [2:0]       swActive;
    logic [31:0]      count;
    logic [31:0]      preset;
    logic             irqEn;
    logic             armed;
    logic             irqReq;
    logic             ack;
    logic [31:0]      rdData;
    logic [DIV_W-1:0] div;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // helpers
  // fold a value into the configured width
  function automatic logic [31:0] fitw(input logic [31:0] v, input logic wide);
    fitw = wide ? v : (v & MASK16);
  endfunction

  // quadrature step: {valid, up}
  function automatic logic [1:0] quadStep(input logic [1:0] p, input logic [1:0] c,
                                          input mode_t m);
    logic aEdge;
    logic bEdge;
    logic up;
    aEdge = p[0] ^ c[0];
    bEdge = p[1] ^ c[1];
    up    = c[0] ^ p[1];
    case (m)
      QUAD_X1_MODE: quadStep = {aEdge & !bEdge & (c[0] == up), up};
      QUAD_X2_MODE: quadStep = {aEdge & !bEdge, up};
      QUAD_X4_MODE: quadStep = {aEdge ^ bEdge, up};
      default:      quadStep = 2'b00;
    endcase
  endfunction

  // ==========================================================
  // effective inputs
  logic [1:0]  cntEff;
  logic        maskEff;
  logic        clearEff;
  logic        busReq;
  logic        wrCur;
  logic        wrPre;
  logic        wrCfg;
  logic        wrUpd;
  logic        tick;
  logic        stepValid;
  logic        stepUp;
  logic [31:0] stepped;
  logic [1:0]  qs;

  // inputs pass two flops before use; polarity applied after
  assign cntEff   = st.sync2[1:0] ^ st.invert[1:0];
  assign maskEff  = (st.sync2[2] ^ st.invert[2]) | st.swActive[SW_MASK_BIT];
  assign clearEff = (st.sync2[3] ^ st.invert[3]) | st.swActive[SW_CLEAR_BIT];

  // bus decode; a write takes effect on the edge that raises ack, one edge before it is sampled
  assign busReq = wbReq.cyc & wbReq.stb & !st.ack;
  assign wrCur  = busReq & wbReq.we & (wbReq.adr == OFF_CURRENT);
  assign wrPre  = busReq & wbReq.we & (wbReq.adr == OFF_PRESET);
  assign wrCfg  = busReq & wbReq.we & (wbReq.adr == OFF_CONFIG);
  assign wrUpd  = busReq & wbReq.we & (wbReq.adr == OFF_UPDATE);
  assign tick   = st.div == DIV_W'(TICK_DIV - 1);
  assign qs     = quadStep(st.prevCnt, cntEff, st.mode);

  // ==========================================================
  // count step decode per mode
  always_comb begin
    stepValid = 1'b0;
    stepUp    = 1'b1;
    if (st.timerMode) begin
      stepValid = tick;
    end else begin
      case (st.mode)
        UPDOWN_X1: begin
          stepValid = (cntEff[0] & !st.prevCnt[0]) ^ (cntEff[1] & !st.prevCnt[1]);
          stepUp    = cntEff[0] & !st.prevCnt[0];
        end
        UPDOWN_X2: begin
          stepValid = (cntEff[0] ^ st.prevCnt[0]) ^ (cntEff[1] ^ st.prevCnt[1]);
          stepUp    = cntEff[0] ^ st.prevCnt[0];
        end
        PULSE_DIR_MODE: begin
          stepValid = cntEff[0] & !st.prevCnt[0];
          stepUp    = !cntEff[1];
        end
        QUAD_X1_MODE, QUAD_X2_MODE, QUAD_X4_MODE: begin
          stepValid = qs[1];
          stepUp    = qs[0];
        end
        default: begin
          stepValid = 1'b0;
          stepUp    = 1'b1;
        end
      endcase
      // software direction reverses the sense, applied at update only
      stepUp = stepUp ^ st.swActive[SW_DIR_BIT];
    end
    // wrap modulo the width
    stepped = fitw(stepUp ? st.count + ONE32 : st.count - ONE32, st.wide);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st         = st;
    next_st.sync1   = {pins.clear, pins.mask, pins.count};
    next_st.sync2   = st.sync1;
    next_st.prevCnt = cntEff;
    next_st.irqReq  = 1'b0;
    next_st.ack     = busReq;
    next_st.div     = tick ? '0 : st.div + DIV_W'(1);

    // counting, clear first, then mask
    if (clearEff) begin
      next_st.count = ZERO32;
    end else if (!maskEff && stepValid) begin
      next_st.count = stepped;
      // request at the moment the count reaches the preset
      if (stepped == st.preset && st.armed && st.irqEn) begin
        next_st.irqReq = 1'b1;
        if (st.wide) begin
          next_st.armed = 1'b0;
        end
      end
    end

    // register writes
    if (wrCur && !clearEff) begin
      next_st.count = fitw(wbReq.dat, st.wide);
    end
    if (wrPre) begin
      next_st.preset = fitw(wbReq.dat, st.wide);
      // a preset equal to the count never fires in 32-bit width
      next_st.armed  = !(st.wide && fitw(wbReq.dat, st.wide) == st.count);
    end
    if (wrCfg) begin
      next_st.mode      = mode_t'(wbReq.dat[CFG_MODE_LSB +: 3]);
      next_st.wide      = wbReq.dat[CFG_WIDE_BIT];
      next_st.timerMode = wbReq.dat[CFG_TIMER_BIT];
      next_st.invert    = wbReq.dat[CFG_INV_LSB +: 4];
      next_st.irqEn     = 1'b1;
      next_st.armed     = 1'b1;
      // keep a step or a clear of this cycle, then truncate to the new width
      next_st.count     = fitw(next_st.count, wbReq.dat[CFG_WIDE_BIT]);
      next_st.preset    = fitw(next_st.preset, wbReq.dat[CFG_WIDE_BIT]);
      // a new count polarity must not look like a count edge
      next_st.prevCnt   = st.sync2[1:0] ^ wbReq.dat[CFG_INV_LSB +: 2];
    end
    if (busReq && wbReq.we && wbReq.adr == OFF_SWCTL) begin
      next_st.swShadow = wbReq.dat[2:0];
    end
    if (wrUpd) begin
      next_st.swActive = st.swShadow;
    end
    if (busReq && wbReq.we && wbReq.adr == OFF_IRQCTL) begin
      if (wbReq.dat[IRQ_EN_BIT]) begin
        next_st.irqEn = 1'b1;
      end else if (wbReq.dat[IRQ_DIS_BIT]) begin
        next_st.irqEn = 1'b0;
      end
    end

    // read data; the current count is captured only by this read
    next_st.rdData = ZERO32;
    if (busReq && !wbReq.we) begin
      case (wbReq.adr)
        OFF_CONFIG:  next_st.rdData = {20'h0, st.invert, 3'h0, st.timerMode,
                                       st.wide, st.mode};
        OFF_SWCTL:   next_st.rdData = {21'h0, st.swActive, 5'h0, st.swShadow};
        OFF_CURRENT: next_st.rdData = st.count;
        OFF_PRESET:  next_st.rdData = st.preset;
        OFF_IRQCTL:  next_st.rdData = {29'h0, st.armed, 1'b0, st.irqEn};
        default:     next_st.rdData = ZERO32;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{sync1: 4'h0, sync2: 4'h0, prevCnt: 2'h0, mode: UPDOWN_X1, wide: 1'b1,
              timerMode: 1'b0, invert: INV_RESET, swShadow: SW_RESET, swActive: SW_RESET,
              count: ZERO32, preset: ZERO32, irqEn: 1'b1, armed: 1'b1, irqReq: 1'b0,
              ack: 1'b0, rdData: ZERO32, div: '0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign wbRsp.ack = st.ack;
  assign wbRsp.dat = st.rdData;
  assign irqReq    = st.irqReq;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_pulseRise;
    st.mode == PULSE_DIR_MODE && !st.timerMode && !maskEff && !clearEff && !wrCur
      && !wrCfg && cntEff[0] && !st.prevCnt[0];
  endsequence

  property p_clearHold;
    clearEff |=> st.count == ZERO32;
  endproperty
  a_clearHold: assert property (p_clearHold) else $error("count not zero under clear");

  property p_maskFreeze;
    maskEff && !clearEff && !wrCur && !wrCfg |=> $stable(st.count);
  endproperty
  a_maskFreeze: assert property (p_maskFreeze) else $error("count moved while masked");

  property p_irqEqual;
    irqReq |-> st.count == st.preset && $past(st.irqEn) && $past(st.armed);
  endproperty
  a_irqEqual: assert property (p_irqEqual) else $error("request without match");

  property p_irqOff;
    !st.irqEn && !wrCfg ##1 !st.irqEn |-> !irqReq;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("request while disabled");

  property p_cfgEnable;
    wrCfg |=> st.irqEn && st.armed;
  endproperty
  a_cfgEnable: assert property (p_cfgEnable) else $error("mode set left irq off");

  property p_pulseDir;
    s_pulseRise |=> st.count == fitw($past(cntEff[1] ^ st.swActive[SW_DIR_BIT])
                     ? $past(st.count) - ONE32 : $past(st.count) + ONE32, st.wide);
  endproperty
  a_pulseDir: assert property (p_pulseDir) else $error("pulse step wrong");

  property p_rearm32;
    st.wide && irqReq && !$past(wrPre) |-> !st.armed;
  endproperty
  a_rearm32: assert property (p_rearm32) else $error("still armed after hit");

  property p_wrap16;
    !st.wide |-> st.count[31:16] == 16'h0000;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit count overflow");

  property p_swUpdate;
    $changed(st.swActive) |-> $past(wrUpd);
  endproperty
  a_swUpdate: assert property (p_swUpdate) else $error("soft control applied early");

  property p_ackPulse;
    wbRsp.ack |=> !wbRsp.ack;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack held two cycles");

  // ==========================================================
  // bus answers and host loads
  property p_ackAnswer;
    busReq |=> wbRsp.ack;
  endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("request not acked");

  property p_rdIdle;
    !wbRsp.ack |-> wbRsp.dat == ZERO32;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data without ack");

  property p_readCurrent;
    busReq && !wbReq.we && wbReq.adr == OFF_CURRENT |=> wbRsp.dat == $past(st.count);
  endproperty
  a_readCurrent: assert property (p_readCurrent) else $error("sampled count wrong");

  property p_loadCurrent;
    wrCur && !clearEff |=> st.count == fitw($past(wbReq.dat), $past(st.wide));
  endproperty
  a_loadCurrent: assert property (p_loadCurrent) else $error("count load lost");

  property p_loadPreset;
    wrPre |=> st.preset == fitw($past(wbReq.dat), $past(st.wide));
  endproperty
  a_loadPreset: assert property (p_loadPreset) else $error("preset load lost");

  // ==========================================================
  // compare arming and request gating
  property p_equalNoArm;
    wrPre && st.wide && wbReq.dat == st.count |=> !st.armed;
  endproperty
  a_equalNoArm: assert property (p_equalNoArm) else $error("equal preset armed");

  property p_noHitUnarmed;
    st.wide && !st.armed && !wrPre && !wrCfg |=> !irqReq;
  endproperty
  a_noHitUnarmed: assert property (p_noHitUnarmed) else $error("request unarmed");

  property p_heldNoIrq;
    maskEff || clearEff |=> !irqReq;
  endproperty
  a_heldNoIrq: assert property (p_heldNoIrq) else $error("request while held");

  property p_irqDisable;
    busReq && wbReq.we && wbReq.adr == OFF_IRQCTL && !wbReq.dat[IRQ_EN_BIT]
      && wbReq.dat[IRQ_DIS_BIT] |=> !st.irqEn;
  endproperty
  a_irqDisable: assert property (p_irqDisable) else $error("disable op ignored");

  // ==========================================================
  // count edges per mode
  // quadrature mode with nothing else touching the count
  sequence s_quadCalm;
    (st.mode == QUAD_X1_MODE || st.mode == QUAD_X2_MODE || st.mode == QUAD_X4_MODE)
      && !st.timerMode && !maskEff && !clearEff && !wrCur && !wrCfg
      && !st.swActive[SW_DIR_BIT];
  endsequence

  property p_pulseIdle;
    st.mode == PULSE_DIR_MODE && !st.timerMode && !clearEff && !wrCur && !wrCfg
      && !(cntEff[0] && !st.prevCnt[0]) |=> $stable(st.count);
  endproperty
  a_pulseIdle: assert property (p_pulseIdle) else $error("pulse moved, no edge");

  property p_quadLead;
    s_quadCalm ##0 (cntEff == 2'b01 && st.prevCnt == 2'b00)
      |=> st.count == fitw($past(st.count) + ONE32, st.wide);
  endproperty
  a_quadLead: assert property (p_quadLead) else $error("leading A not up");

  property p_quadLag;
    s_quadCalm ##0 (cntEff == 2'b00 && st.prevCnt == 2'b01)
      |=> st.count == fitw($past(st.count) - ONE32, st.wide);
  endproperty
  a_quadLag: assert property (p_quadLag) else $error("lagging A not down");

  property p_quadX1Quiet;
    st.mode == QUAD_X1_MODE && !st.timerMode && !clearEff && !wrCur && !wrCfg
      && cntEff[0] == st.prevCnt[0] |=> $stable(st.count);
  endproperty
  a_quadX1Quiet: assert property (p_quadX1Quiet) else $error("x1 moved, no A edge");

  property p_x2NoB;
    st.mode == QUAD_X2_MODE && !st.timerMode && !clearEff && !wrCur && !wrCfg
      && cntEff[0] == st.prevCnt[0] |=> $stable(st.count);
  endproperty
  a_x2NoB: assert property (p_x2NoB) else $error("x2 counted a B edge");

  property p_x4B;
    s_quadCalm ##0 (st.mode == QUAD_X4_MODE && cntEff[0] == st.prevCnt[0]
      && cntEff[1] != st.prevCnt[1]) |=> !$stable(st.count);
  endproperty
  a_x4B: assert property (p_x4B) else $error("x4 missed a B edge");

  property p_timerTick;
    st.timerMode && tick && !maskEff && !clearEff && !wrCur && !wrCfg
      |=> st.count == fitw($past(st.count) + ONE32, st.wide);
  endproperty
  a_timerTick: assert property (p_timerTick) else $error("timer tick lost");

endmodule

/* File: pkg/qpc_pkg.sv */
// constants, types and register map of the quadrature pulse counter
// ==========================================================
// Overview of operation
// - inputs default active high, one active
// - per-input polarity inversion for count, mask, clear
// - mask active: no counting, values held
// - clear active: count held at zero
// - explicit load writes, explicit sampling reads
// - interrupt request when count becomes preset
// - software controls applied at I/O update
// - interrupt disabled: counting continues, no request
// - configuring a mode enables the interrupt
// - pulse/direction: rising pulse edge, dir low adds
// - effective mask/clear are soft OR hard
// - quadrature: A leads counts up, lags down
// - x1: A rise up, A fall down
// - x2: both A edges count
// - x4: all A and B edges count
// - both widths interrupt up or down, any values
// - 32-bit: preset equal to count is not armed
// - 32-bit: rewrite preset to re-arm after hit
// - channel works as pulse counter or timer
// - two inputs become up/down, pulse/dir, or A/B
// - six counting modes
// - count width 32 or 16 bits
package qpc_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_SWCTL   = 8'h04;
  localparam logic [7:0] OFF_UPDATE  = 8'h08;
  localparam logic [7:0] OFF_CURRENT = 8'h0C;
  localparam logic [7:0] OFF_PRESET  = 8'h10;
  localparam logic [7:0] OFF_IRQCTL  = 8'h14;

  // ==========================================================
  // field positions
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_WIDE_BIT  = 3;
  localparam int CFG_TIMER_BIT = 4;
  localparam int CFG_INV_LSB   = 8;
  localparam int SW_MASK_BIT   = 0;
  localparam int SW_CLEAR_BIT  = 1;
  localparam int SW_DIR_BIT    = 2;
  localparam int SW_ACT_LSB    = 8;
  localparam int IRQ_EN_BIT    = 0;
  localparam int IRQ_DIS_BIT   = 1;
  localparam int IRQ_ARM_BIT   = 2;

  // ==========================================================
  // reset values and widths
  localparam logic [31:0] ZERO32    = 32'h0000_0000;
  localparam logic [31:0] MASK16    = 32'h0000_FFFF;
  localparam logic [31:0] ONE32     = 32'h0000_0001;
  localparam logic [3:0]  INV_RESET = 4'h0;
  localparam logic [2:0]  SW_RESET  = 3'h0;
  localparam int          DIV_W     = 16;

  // ==========================================================
  // timer time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // counting modes
  typedef enum logic [2:0] {
    UPDOWN_X1      = 3'b000,
    UPDOWN_X2      = 3'b001,
    PULSE_DIR_MODE = 3'b010,
    QUAD_X1_MODE   = 3'b011,
    QUAD_X2_MODE   = 3'b100,
    QUAD_X4_MODE   = 3'b101
  } mode_t;

  // wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // external pins: count pair and control pair
  typedef struct packed {
    logic [1:0] count;
    logic       mask;
    logic       clear;
  } pins_t;

endpackage

/* File: tb/pin_driver.sv */
// pin driver standing in for the encoder or pulse sensor
module pin_driver (
  // clock
  input  wire logic     ref_clk,
  // sensor pins
  output qpc_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import qpc_pkg::*;

  // ==========================================================
  // phase position of the quadrature pair
  logic [1:0] idx = 2'b00;
  initial pins = '0;

  // four clocks a level, more than the two-flop sync needs
  task automatic hold();
    repeat (4) @(posedge ref_clk);
  endtask

  // full quadrature cycles, phase A on the even line
  task automatic quad(input int n, input logic fwd);
    repeat (4 * n) begin
      idx = fwd ? idx + 2'd1 : idx - 2'd1;
      pins.count <= {idx[1], idx[1] ^ idx[0]};
      hold();
    end
  endtask

  // pulses with direction set up a whole level ahead
  task automatic pulse(input int n, input logic dir);
    pins.count <= {dir, 1'b0};
    hold();
    repeat (n) begin
      pins.count <= {dir, 1'b1};
      hold();
      pins.count <= {dir, 1'b0};
      hold();
    end
    pins.count <= 2'b00;
    hold();
  endtask

  // hardware mask and clear levels
  task automatic ctl(input logic m, input logic c);
    pins.mask  <= m;
    pins.clear <= c;
    hold();
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the quadrature pulse counter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import qpc_pkg::*;

  // ==========================================================
  // design signals and bookkeeping
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  wb_req_t     wbReq     = '0;
  wb_rsp_t     wbRsp;
  pins_t       pins;
  logic        irqReq;
  logic        d;
  logic [31:0] cur;
  logic [31:0] expQ[$];
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          irqCnt    = 0;
  int          seed      = 88415;
  localparam int TB_TICK = 4;

  always #10 ref_clk = ~ref_clk;

  // short tick so the timer base stays cheap
  quadrature_pulse_counter #(.TICK_DIV(TB_TICK)) quadrature_pulse_counter_inst (
    .ref_clk(ref_clk),
    .resetn (resetn),
    .wbReq  (wbReq),
    .wbRsp  (wbRsp),
    .pins   (pins),
    .irqReq (irqReq)
  );
  pin_driver pin_driver_inst (
    .ref_clk(ref_clk),
    .pins   (pins)
  );

  // ==========================================================
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge ref_clk);
    wbReq <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (wbRsp.ack === 1'b1) break;
    end
    wbReq <= '0;
    if (i == 20) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask

  // the expected word is noted before the read goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wb(1'b0, a, ZERO32);
  endtask

  // watcher: read answers against the oldest note, irq pulses counted
  always @(posedge ref_clk) begin
    if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0) begin
      check(wbRsp.dat, expQ.pop_front());
    end
    if (irqReq === 1'b1) irqCnt++;
  end

  // hang guard
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFF_CONFIG, 32'h0000_0008);
    rd(OFF_IRQCTL, 32'h0000_0005);
    // up/down x1, x2 and pulse/direction, three up pulses each
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CONFIG, 32'h0000_0008 | 32'(m));
      wr(OFF_CURRENT, 32'h0000_0010);
      pin_driver_inst.pulse(3, 1'b0);
      rd(OFF_CURRENT, (m == 1) ? 32'h0000_0016 : 32'h0000_0013);
    end
    // random directions, direction taken at the pulse edge
    cur = 32'h0000_0013;
    repeat (6) begin
      d = 1'($random(seed));
      pin_driver_inst.pulse(1, d);
      cur = d ? cur - ONE32 : cur + ONE32;
    end
    rd(OFF_CURRENT, cur);
    // quadrature x1, x2, x4: three cycles ahead, one behind
    for (int m = 3; m < 6; m++) begin
      wr(OFF_CONFIG, 32'h0000_0008 | 32'(m));
      wr(OFF_CURRENT, ZERO32);
      pin_driver_inst.quad(3, 1'b1);
      pin_driver_inst.quad(1, 1'b0);
      rd(OFF_CURRENT, 32'(2 << (m - 3)));
    end
    // hardware mask, then clear that also beats a host load
    pin_driver_inst.ctl(1'b1, 1'b0);
    pin_driver_inst.quad(1, 1'b1);
    rd(OFF_CURRENT, 32'h0000_0008);
    pin_driver_inst.ctl(1'b0, 1'b1);
    wr(OFF_CURRENT, 32'h0000_0005);
    pin_driver_inst.quad(1, 1'b1);
    rd(OFF_CURRENT, ZERO32);
    pin_driver_inst.ctl(1'b0, 1'b0);
    pin_driver_inst.quad(1, 1'b1);
    rd(OFF_CURRENT, 32'h0000_0004);
    // soft mask waits for the update write
    wr(OFF_SWCTL, ONE32);
    pin_driver_inst.quad(1, 1'b1);
    rd(OFF_CURRENT, 32'h0000_0008);
    wr(OFF_UPDATE, ZERO32);
    rd(OFF_SWCTL, 32'h0000_0101);
    pin_driver_inst.quad(1, 1'b1);
    rd(OFF_CURRENT, 32'h0000_0008);
    wr(OFF_SWCTL, ZERO32);
    wr(OFF_UPDATE, ZERO32);
    // mask polarity inverted: a low pin now masks
    wr(OFF_CONFIG, 32'h0000_040A);
    wr(OFF_CURRENT, ZERO32);
    pin_driver_inst.pulse(1, 1'b0);
    rd(OFF_CURRENT, ZERO32);
    pin_driver_inst.ctl(1'b1, 1'b0);
    pin_driver_inst.pulse(1, 1'b0);
    rd(OFF_CURRENT, ONE32);
    pin_driver_inst.ctl(1'b0, 1'b0);
    // 32-bit compare: hit, no re-hit, down hit, equal preset, disabled
    wr(OFF_CONFIG, 32'h0000_000A);
    wr(OFF_CURRENT, ZERO32);
    wr(OFF_PRESET, 32'h0000_0003);
    pin_driver_inst.pulse(3, 1'b0);
    check(32'(irqCnt), ONE32);
    pin_driver_inst.pulse(1, 1'b1);
    pin_driver_inst.pulse(1, 1'b0);
    check(32'(irqCnt), ONE32);
    wr(OFF_PRESET, ONE32);
    pin_driver_inst.pulse(2, 1'b1);
    check(32'(irqCnt), 32'h0000_0002);
    wr(OFF_PRESET, ONE32);
    rd(OFF_IRQCTL, ONE32);
    wr(OFF_IRQCTL, 32'h0000_0002);
    wr(OFF_PRESET, 32'h0000_0003);
    pin_driver_inst.pulse(2, 1'b0);
    check(32'(irqCnt), 32'h0000_0002);
    rd(OFF_CURRENT, 32'h0000_0003);
    // 16-bit: configuring re-enables, wrap hits preset zero
    wr(OFF_CONFIG, 32'h0000_0002);
    rd(OFF_IRQCTL, 32'h0000_0005);
    wr(OFF_CURRENT, MASK16);
    wr(OFF_PRESET, ZERO32);
    pin_driver_inst.pulse(1, 1'b0);
    check(32'(irqCnt), 32'h0000_0003);
    pin_driver_inst.pulse(1, 1'b1);
    rd(OFF_CURRENT, MASK16);
    rd(OFF_CONFIG, 32'h0000_0002);
    // soft direction reverses the pulse sense, soft clear holds zero
    wr(OFF_SWCTL, 32'h0000_0004);
    wr(OFF_UPDATE, ZERO32);
    pin_driver_inst.pulse(1, 1'b0);
    rd(OFF_CURRENT, 32'h0000_FFFE);
    wr(OFF_SWCTL, 32'h0000_0002);
    wr(OFF_UPDATE, ZERO32);
    rd(OFF_CURRENT, ZERO32);
    wr(OFF_SWCTL, ZERO32);
    wr(OFF_UPDATE, ZERO32);
    // timer: load lands one edge before ack, sample one edge after request,
    // so the wait plus two gives a whole number of tick periods
    wr(OFF_CONFIG, 32'h0000_0018);
    wr(OFF_CURRENT, ZERO32);
    repeat (40 - 2) @(posedge ref_clk);
    rd(OFF_CURRENT, 32'(40 / TB_TICK));
    final_report();
  end
endmodule
